// ===== hdl/lmsf_master.sv
/*
  lmsf_master: schedule-table master end. Holds two schedule tables in flops,
  runs the active one slot by slot, sends headers and published data, and
  collects responses. Assumes the slave answers on the same clock.
*/
`timescale 1ns/1ps
// Contract
// - pid carries id plus two parity bits
// - frame identifier limited to six bits
// - ids 0x3c and 0x3d diagnostic only
// - ids 0x3e and 0x3f never used
// - each entry reserves its delay slot
// - one active table run in order
// - publisher sends data then checksum
// - only master switches active table
// - diag request 0x3c, response 0x3d
// - diag frames eight bytes, classic checksum
// - long diag payloads span several frames; not done here, each diag slot moves one eight-byte frame
// - example command frame field layout
// - temperature raw encoding with special codes
module lmsf_master #(
  parameter int N_ENT       = lmsf_pkg::EX_N_ENT,
  parameter int TICK_CYCLES = lmsf_pkg::MS_CYCLES
) (
  // clock and reset
  input  logic        clk_sys_i,
  input  logic        nrst_i,
  // link
  lmsf_if.master      lin,
  // table control
  input  logic        sched_sel_i,
  input  logic        tbl_wr_i,
  input  logic        tbl_sel_i,
  input  logic [$clog2(N_ENT > 1 ? N_ENT : 2)-1:0] tbl_idx_i,
  input  logic [5:0]  tbl_id_i,
  input  logic [3:0]  tbl_len_i,
  input  logic        tbl_tx_i,
  input  logic [7:0]  tbl_delay_i,
  // published data
  input  logic [63:0] tx_data_i,
  input  logic [63:0] diag_req_data_i,
  // status
  output logic        slot_start_o,
  output logic [5:0]  cur_id_o,
  output logic        act_tbl_o,
  output logic        id_rej_o,
  output logic        rx_valid_o,
  output logic        rx_err_o,
  output logic        rx_miss_o,
  output logic [5:0]  rx_id_o,
  output logic [63:0] rx_data_o
);
  localparam int IDX_W = $clog2(N_ENT > 1 ? N_ENT : 2);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N_ENT - 1);

  // table storage, two tables
  logic [5:0] t_id_ff  [2][N_ENT];
  logic [3:0] t_len_ff [2][N_ENT];
  logic       t_tx_ff  [2][N_ENT];
  logic [7:0] t_dly_ff [2][N_ENT];
  logic [5:0] nxt_t_id  [2][N_ENT];
  logic [3:0] nxt_t_len [2][N_ENT];
  logic       nxt_t_tx  [2][N_ENT];
  logic [7:0] nxt_t_dly [2][N_ENT];

  // writes land in the stored tables only; a running slot keeps its copy
  always_comb begin
    nxt_t_id  = t_id_ff;
    nxt_t_len = t_len_ff;
    nxt_t_tx  = t_tx_ff;
    nxt_t_dly = t_dly_ff;
    if (tbl_wr_i) begin
      nxt_t_id[tbl_sel_i][tbl_idx_i]  = tbl_id_i;
      nxt_t_len[tbl_sel_i][tbl_idx_i] = lmsf_pkg::lmsf_fix_len(tbl_len_i);
      nxt_t_tx[tbl_sel_i][tbl_idx_i]  = tbl_tx_i;
      nxt_t_dly[tbl_sel_i][tbl_idx_i] = tbl_delay_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      for (int t = 0; t < 2; t++) begin
        for (int e = 0; e < N_ENT; e++) begin
          t_id_ff[t][e]  <= lmsf_pkg::RST_ID[e % lmsf_pkg::EX_N_ENT];
          t_len_ff[t][e] <= lmsf_pkg::RST_LEN[e % lmsf_pkg::EX_N_ENT];
          t_tx_ff[t][e]  <= lmsf_pkg::RST_TX[e % lmsf_pkg::EX_N_ENT];
          t_dly_ff[t][e] <= lmsf_pkg::DEFAULT_DELAY_MS;
        end
      end
    end else begin
      t_id_ff  <= nxt_t_id;
      t_len_ff <= nxt_t_len;
      t_tx_ff  <= nxt_t_tx;
      t_dly_ff <= nxt_t_dly;
    end
  end

  // slot timer and frame engine state
  lmsf_pkg::lmsf_state_t state_ff, nxt_state;
  logic [31:0]      tick_ff, nxt_tick;
  logic [7:0]       ms_ff, nxt_ms;
  logic             first_ff, nxt_first;
  logic [IDX_W-1:0] idx_ff, nxt_idx;
  logic             act_ff, nxt_act;
  logic [5:0]       cid_ff, nxt_cid;
  logic [3:0]       len_ff, nxt_len;
  logic             ctx_ff, nxt_ctx;
  logic [7:0]       dly_ff, nxt_dly;
  logic [63:0]      dat_ff, nxt_dat;
  logic [3:0]       cnt_ff, nxt_cnt;
  logic             slot_ff, nxt_slot;
  logic             rej_ff, nxt_rej;
  logic             rxv_ff, nxt_rxv;
  logic             rxe_ff, nxt_rxe;
  logic             miss_ff, nxt_miss;
  logic [5:0]       rxid_ff, nxt_rxid;
  logic [63:0]      rxd_ff, nxt_rxd;
  logic             brk_ff, nxt_brk;
  logic             mvld_ff, nxt_mvld;
  logic [7:0]       mbyte_ff, nxt_mbyte;
  logic             tick_wrap;
  logic             slot_end;
  logic [5:0]       e_id;

  assign tick_wrap = tick_ff == 32'(TICK_CYCLES - 1);
  // a zero delay still holds the slot for one unit
  assign slot_end  = first_ff |
                     (tick_wrap & (({1'b0, ms_ff} + 9'h001) >= {1'b0, dly_ff}));

  always_comb begin
    nxt_state = state_ff;
    nxt_tick  = tick_wrap ? 32'h0 : tick_ff + 32'h1;
    nxt_ms    = (tick_wrap && ms_ff != 8'hff) ? ms_ff + 8'h01 : ms_ff;
    nxt_first = 1'b0;
    nxt_idx   = idx_ff;
    nxt_act   = act_ff;
    nxt_cid   = cid_ff;
    nxt_len   = len_ff;
    nxt_ctx   = ctx_ff;
    nxt_dly   = dly_ff;
    nxt_dat   = dat_ff;
    nxt_cnt   = cnt_ff;
    nxt_slot  = 1'b0;
    nxt_rej   = 1'b0;
    nxt_rxv   = 1'b0;
    nxt_rxe   = rxe_ff;
    nxt_miss  = miss_ff;
    nxt_rxid  = rxid_ff;
    nxt_rxd   = rxd_ff;
    e_id      = 6'h00;
    unique case (state_ff)
      lmsf_pkg::LMSF_WAIT: ;
      lmsf_pkg::LMSF_BRK:  nxt_state = lmsf_pkg::LMSF_SYNC;
      lmsf_pkg::LMSF_SYNC: nxt_state = lmsf_pkg::LMSF_PID;
      lmsf_pkg::LMSF_PID: begin
        nxt_cnt   = 4'h0;
        nxt_state = ctx_ff ? lmsf_pkg::LMSF_TXD : lmsf_pkg::LMSF_RXD;
      end
      lmsf_pkg::LMSF_TXD: begin
        if (cnt_ff == len_ff - 4'h1) begin
          nxt_state = lmsf_pkg::LMSF_TXC;
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      lmsf_pkg::LMSF_TXC:  nxt_state = lmsf_pkg::LMSF_WAIT;
      lmsf_pkg::LMSF_RXD: begin
        if (lin.s_vld) begin
          if (cnt_ff == len_ff) begin
            // last byte is the checksum of the bytes gathered so far
            nxt_state = lmsf_pkg::LMSF_WAIT;
            nxt_rxv   = 1'b1;
            nxt_miss  = 1'b0;
            nxt_rxid  = cid_ff;
            nxt_rxd   = dat_ff;
            nxt_rxe   = lin.s_byte != lmsf_pkg::lmsf_csum(dat_ff, len_ff);
          end else begin
            nxt_dat[{cnt_ff[2:0], 3'b000} +: 8] = lin.s_byte;
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
      end
    endcase
    if (slot_end) begin
      // an unanswered response slot is reported as missing
      if (state_ff == lmsf_pkg::LMSF_RXD) begin
        nxt_rxv  = 1'b1;
        nxt_miss = 1'b1;
        nxt_rxe  = 1'b0;
        nxt_rxid = cid_ff;
        nxt_rxd  = dat_ff;
      end
      nxt_tick = 32'h0;
      nxt_ms   = 8'h00;
      nxt_slot = 1'b1;
      if (first_ff || idx_ff == LAST_IDX) begin
        nxt_idx = '0;
        nxt_act = sched_sel_i;
      end else begin
        nxt_idx = idx_ff + IDX_W'(1);
      end
      e_id    = t_id_ff[nxt_act][nxt_idx];
      nxt_cid = e_id;
      nxt_dly = t_dly_ff[nxt_act][nxt_idx];
      nxt_cnt = 4'h0;
      if (e_id == lmsf_pkg::ID_DIAG_REQ) begin
        // each request slot sends the eight bytes present on diag_req_data_i
        nxt_ctx = 1'b1;
        nxt_len = lmsf_pkg::DIAG_LEN;
        nxt_dat = diag_req_data_i;
      end else if (e_id == lmsf_pkg::ID_DIAG_RSP) begin
        nxt_ctx = 1'b0;
        nxt_len = lmsf_pkg::DIAG_LEN;
        nxt_dat = 64'h0;
      end else begin
        nxt_ctx = t_tx_ff[nxt_act][nxt_idx];
        nxt_len = t_len_ff[nxt_act][nxt_idx];
        nxt_dat = nxt_ctx ? tx_data_i : 64'h0;
      end
      if (e_id == lmsf_pkg::ID_RSV_LO || e_id == lmsf_pkg::ID_RSV_HI) begin
        nxt_state = lmsf_pkg::LMSF_WAIT;
        nxt_rej   = 1'b1;
      end else begin
        nxt_state = lmsf_pkg::LMSF_BRK;
      end
    end
  end

  // link outputs follow the next state so they leave straight from flops
  always_comb begin
    nxt_brk   = nxt_state == lmsf_pkg::LMSF_BRK;
    nxt_mvld  = nxt_state inside {lmsf_pkg::LMSF_SYNC, lmsf_pkg::LMSF_PID,
                                  lmsf_pkg::LMSF_TXD, lmsf_pkg::LMSF_TXC};
    nxt_mbyte = 8'h00;
    unique case (nxt_state)
      lmsf_pkg::LMSF_SYNC: nxt_mbyte = lmsf_pkg::SYNC_BYTE;
      lmsf_pkg::LMSF_PID:  nxt_mbyte = lmsf_pkg::lmsf_pid(nxt_cid);
      lmsf_pkg::LMSF_TXD:  nxt_mbyte = nxt_dat[{nxt_cnt[2:0], 3'b000} +: 8];
      lmsf_pkg::LMSF_TXC:  nxt_mbyte = lmsf_pkg::lmsf_csum(nxt_dat, nxt_len);
      lmsf_pkg::LMSF_WAIT, lmsf_pkg::LMSF_BRK, lmsf_pkg::LMSF_RXD: nxt_mbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_ff <= lmsf_pkg::LMSF_WAIT;
      tick_ff  <= 32'h0;
      ms_ff    <= 8'h00;
      first_ff <= 1'b1;
      idx_ff   <= '0;
      act_ff   <= 1'b0;
      cid_ff   <= 6'h00;
      len_ff   <= 4'h0;
      ctx_ff   <= 1'b0;
      dly_ff   <= lmsf_pkg::DEFAULT_DELAY_MS;
      dat_ff   <= 64'h0;
      cnt_ff   <= 4'h0;
      slot_ff  <= 1'b0;
      rej_ff   <= 1'b0;
      rxv_ff   <= 1'b0;
      rxe_ff   <= 1'b0;
      miss_ff  <= 1'b0;
      rxid_ff  <= 6'h00;
      rxd_ff   <= 64'h0;
      brk_ff   <= 1'b0;
      mvld_ff  <= 1'b0;
      mbyte_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      tick_ff  <= nxt_tick;
      ms_ff    <= nxt_ms;
      first_ff <= nxt_first;
      idx_ff   <= nxt_idx;
      act_ff   <= nxt_act;
      cid_ff   <= nxt_cid;
      len_ff   <= nxt_len;
      ctx_ff   <= nxt_ctx;
      dly_ff   <= nxt_dly;
      dat_ff   <= nxt_dat;
      cnt_ff   <= nxt_cnt;
      slot_ff  <= nxt_slot;
      rej_ff   <= nxt_rej;
      rxv_ff   <= nxt_rxv;
      rxe_ff   <= nxt_rxe;
      miss_ff  <= nxt_miss;
      rxid_ff  <= nxt_rxid;
      rxd_ff   <= nxt_rxd;
      brk_ff   <= nxt_brk;
      mvld_ff  <= nxt_mvld;
      mbyte_ff <= nxt_mbyte;
    end
  end

  // outputs
  assign lin.brk      = brk_ff;
  assign lin.m_vld    = mvld_ff;
  assign lin.m_byte   = mbyte_ff;
  assign slot_start_o = slot_ff;
  assign cur_id_o     = cid_ff;
  assign act_tbl_o    = act_ff;
  assign id_rej_o     = rej_ff;
  assign rx_valid_o   = rxv_ff;
  assign rx_err_o     = rxe_ff;
  assign rx_miss_o    = miss_ff;
  assign rx_id_o      = rxid_ff;
  assign rx_data_o    = rxd_ff;
endmodule : lmsf_master

// ===== hdl/lmsf_slave.sv
/*
  lmsf_slave: slave node end. Follows headers, publishes its own frame or the
  diagnostic response, receives subscribed frames and decodes the example
  command frame. Assumes headers come only from the master.
*/
`timescale 1ns/1ps
module lmsf_slave (
  // clock and reset
  input  logic        clk_sys_i,
  input  logic        nrst_i,
  // link
  lmsf_if.slave       lin,
  // published frame
  input  logic [5:0]  pub_id_i,
  input  logic [3:0]  pub_len_i,
  input  logic [63:0] pub_data_i,
  input  logic        diag_rsp_rdy_i,
  input  logic [63:0] diag_rsp_data_i,
  // extra subscribed frame
  input  logic [5:0]  sub_id_i,
  input  logic [3:0]  sub_len_i,
  // received frames
  output logic        rx_valid_o,
  output logic        rx_err_o,
  output logic [5:0]  rx_id_o,
  output logic [63:0] rx_data_o,
  output logic        pid_err_o,
  output logic        tx_done_o,
  // decoded example command
  output logic [7:0]  cmd_cnt_o,
  output logic        cmd_ign_o,
  output logic [2:0]  cmd_spd_o,
  output logic [7:0]  cmd_tmp_o,
  output logic [1:0]  tmp_code_o
);
  lmsf_pkg::lmsf_state_t state_ff, nxt_state;
  logic [5:0]  cid_ff, nxt_cid;
  logic [3:0]  len_ff, nxt_len;
  logic [63:0] dat_ff, nxt_dat;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic        rxv_ff, nxt_rxv;
  logic        rxe_ff, nxt_rxe;
  logic [5:0]  rxid_ff, nxt_rxid;
  logic [63:0] rxd_ff, nxt_rxd;
  logic        perr_ff, nxt_perr;
  logic        done_ff, nxt_done;
  logic [7:0]  ccnt_ff, nxt_ccnt;
  logic        cign_ff, nxt_cign;
  logic [2:0]  cspd_ff, nxt_cspd;
  logic [7:0]  ctmp_ff, nxt_ctmp;
  logic [1:0]  tcode_ff, nxt_tcode;
  logic        svld_ff, nxt_svld;
  logic [7:0]  sbyte_ff, nxt_sbyte;
  logic [5:0]  h_id;

  always_comb begin
    nxt_state = state_ff;
    nxt_cid   = cid_ff;
    nxt_len   = len_ff;
    nxt_dat   = dat_ff;
    nxt_cnt   = cnt_ff;
    nxt_rxv   = 1'b0;
    nxt_rxe   = rxe_ff;
    nxt_rxid  = rxid_ff;
    nxt_rxd   = rxd_ff;
    nxt_perr  = 1'b0;
    nxt_done  = 1'b0;
    nxt_ccnt  = ccnt_ff;
    nxt_cign  = cign_ff;
    nxt_cspd  = cspd_ff;
    nxt_ctmp  = ctmp_ff;
    nxt_tcode = tcode_ff;
    h_id      = lin.m_byte[5:0];
    unique case (state_ff)
      lmsf_pkg::LMSF_WAIT, lmsf_pkg::LMSF_BRK: ;
      lmsf_pkg::LMSF_SYNC: begin
        if (lin.m_vld) begin
          nxt_state = (lin.m_byte == lmsf_pkg::SYNC_BYTE) ? lmsf_pkg::LMSF_PID
                                                          : lmsf_pkg::LMSF_WAIT;
        end
      end
      lmsf_pkg::LMSF_PID: begin
        if (lin.m_vld) begin
          nxt_cid   = h_id;
          nxt_cnt   = 4'h0;
          nxt_dat   = 64'h0;
          nxt_state = lmsf_pkg::LMSF_WAIT;
          if (lin.m_byte != lmsf_pkg::lmsf_pid(h_id)) begin
            nxt_perr = 1'b1;
          end else if (h_id == lmsf_pkg::ID_DIAG_RSP) begin
            // no answer when the response is not ready; master sees it missing
            if (diag_rsp_rdy_i) begin
              nxt_state = lmsf_pkg::LMSF_TXD;
              nxt_len   = lmsf_pkg::DIAG_LEN;
              nxt_dat   = diag_rsp_data_i;
            end
          end else if (h_id == lmsf_pkg::ID_DIAG_REQ) begin
            nxt_state = lmsf_pkg::LMSF_RXD;
            nxt_len   = lmsf_pkg::DIAG_LEN;
          end else if (lmsf_pkg::lmsf_is_special(h_id)) begin
            nxt_state = lmsf_pkg::LMSF_WAIT;
          end else if (h_id == pub_id_i) begin
            nxt_state = lmsf_pkg::LMSF_TXD;
            nxt_len   = lmsf_pkg::lmsf_fix_len(pub_len_i);
            nxt_dat   = pub_data_i;
          end else if (h_id == lmsf_pkg::EX_CMD_ID) begin
            nxt_state = lmsf_pkg::LMSF_RXD;
            nxt_len   = lmsf_pkg::EX_CMD_LEN;
          end else if (h_id == sub_id_i) begin
            nxt_state = lmsf_pkg::LMSF_RXD;
            nxt_len   = lmsf_pkg::lmsf_fix_len(sub_len_i);
          end
        end
      end
      lmsf_pkg::LMSF_TXD: begin
        if (cnt_ff == len_ff - 4'h1) begin
          nxt_state = lmsf_pkg::LMSF_TXC;
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      lmsf_pkg::LMSF_TXC: begin
        nxt_state = lmsf_pkg::LMSF_WAIT;
        nxt_done  = 1'b1;
      end
      lmsf_pkg::LMSF_RXD: begin
        if (lin.m_vld) begin
          if (cnt_ff == len_ff) begin
            nxt_state = lmsf_pkg::LMSF_WAIT;
            nxt_rxv   = 1'b1;
            nxt_rxid  = cid_ff;
            nxt_rxd   = dat_ff;
            nxt_rxe   = lin.m_byte != lmsf_pkg::lmsf_csum(dat_ff, len_ff);
            if (cid_ff == lmsf_pkg::EX_CMD_ID && !nxt_rxe) begin
              nxt_ccnt = dat_ff[lmsf_pkg::EX_CNT_POS +: lmsf_pkg::EX_CNT_W];
              nxt_cign = dat_ff[lmsf_pkg::EX_IGN_POS];
              nxt_cspd = dat_ff[lmsf_pkg::EX_SPD_POS +: lmsf_pkg::EX_SPD_W];
              nxt_ctmp = dat_ff[lmsf_pkg::EX_TMP_POS +: lmsf_pkg::EX_TMP_W];
              if (nxt_ctmp == lmsf_pkg::TMP_NOT_SUPP) begin
                nxt_tcode = lmsf_pkg::LMSF_TMP_NSUPP;
              end else if (nxt_ctmp == lmsf_pkg::TMP_NOT_AVAIL) begin
                nxt_tcode = lmsf_pkg::LMSF_TMP_NAVL;
              end else begin
                nxt_tcode = lmsf_pkg::LMSF_TMP_OK;
              end
            end
          end else begin
            nxt_dat[{cnt_ff[2:0], 3'b000} +: 8] = lin.m_byte;
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
      end
    endcase
    // a break restarts header tracking from any point
    if (lin.brk) begin
      nxt_state = lmsf_pkg::LMSF_SYNC;
    end
  end

  // response bytes leave from flops in the same cycle the state is reached
  always_comb begin
    nxt_svld  = nxt_state inside {lmsf_pkg::LMSF_TXD, lmsf_pkg::LMSF_TXC};
    nxt_sbyte = 8'h00;
    if (nxt_state == lmsf_pkg::LMSF_TXD) begin
      nxt_sbyte = nxt_dat[{nxt_cnt[2:0], 3'b000} +: 8];
    end else if (nxt_state == lmsf_pkg::LMSF_TXC) begin
      nxt_sbyte = lmsf_pkg::lmsf_csum(nxt_dat, nxt_len);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_ff <= lmsf_pkg::LMSF_WAIT;
      cid_ff   <= 6'h00;
      len_ff   <= 4'h0;
      dat_ff   <= 64'h0;
      cnt_ff   <= 4'h0;
      rxv_ff   <= 1'b0;
      rxe_ff   <= 1'b0;
      rxid_ff  <= 6'h00;
      rxd_ff   <= 64'h0;
      perr_ff  <= 1'b0;
      done_ff  <= 1'b0;
      ccnt_ff  <= 8'h00;
      cign_ff  <= 1'b0;
      cspd_ff  <= 3'h0;
      ctmp_ff  <= lmsf_pkg::TMP_NOT_AVAIL;
      tcode_ff <= lmsf_pkg::LMSF_TMP_NAVL;
      svld_ff  <= 1'b0;
      sbyte_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cid_ff   <= nxt_cid;
      len_ff   <= nxt_len;
      dat_ff   <= nxt_dat;
      cnt_ff   <= nxt_cnt;
      rxv_ff   <= nxt_rxv;
      rxe_ff   <= nxt_rxe;
      rxid_ff  <= nxt_rxid;
      rxd_ff   <= nxt_rxd;
      perr_ff  <= nxt_perr;
      done_ff  <= nxt_done;
      ccnt_ff  <= nxt_ccnt;
      cign_ff  <= nxt_cign;
      cspd_ff  <= nxt_cspd;
      ctmp_ff  <= nxt_ctmp;
      tcode_ff <= nxt_tcode;
      svld_ff  <= nxt_svld;
      sbyte_ff <= nxt_sbyte;
    end
  end

  // outputs
  assign lin.s_vld  = svld_ff;
  assign lin.s_byte = sbyte_ff;
  assign rx_valid_o = rxv_ff;
  assign rx_err_o   = rxe_ff;
  assign rx_id_o    = rxid_ff;
  assign rx_data_o  = rxd_ff;
  assign pid_err_o  = perr_ff;
  assign tx_done_o  = done_ff;
  assign cmd_cnt_o  = ccnt_ff;
  assign cmd_ign_o  = cign_ff;
  assign cmd_spd_o  = cspd_ff;
  assign cmd_tmp_o  = ctmp_ff;
  assign tmp_code_o = tcode_ff;
endmodule : lmsf_slave

// ===== include/lmsf_if.sv
/*
  lmsf_if: byte-level link between the schedule master and a slave node.
  Assumes one master and one slave on the same clock; no clocking block.
*/
`timescale 1ns/1ps
interface lmsf_if;
  logic       brk;     // break field, one-cycle pulse from master
  logic       m_vld;   // master byte strobe
  logic [7:0] m_byte;
  logic       s_vld;   // slave byte strobe
  logic [7:0] s_byte;

  modport master (output brk, output m_vld, output m_byte, input s_vld, input s_byte);
  modport slave  (input brk, input m_vld, input m_byte, output s_vld, output s_byte);
endinterface : lmsf_if

// ===== include/lmsf_pkg.sv
/*
  lmsf_pkg: shared constants, types and helpers for the frame-level schedule
  master and the slave end. Assumes a byte-level link in which each byte is a
  one-cycle strobe; bit timing is handled elsewhere.
*/
package lmsf_pkg;
  // clock and slot time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int SLOT_UNIT_NS  = 1_000_000;  // table delays count in 1 ms units
  localparam int MS_CYCLES     = SLOT_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] DEFAULT_DELAY_MS = 8'h14;  // 20 ms per slot

  // identifiers
  localparam int ID_W = 6;
  localparam logic [5:0] ID_DIAG_REQ = 6'h3c;
  localparam logic [5:0] ID_DIAG_RSP = 6'h3d;
  localparam logic [5:0] ID_RSV_LO   = 6'h3e;
  localparam logic [5:0] ID_RSV_HI   = 6'h3f;
  localparam logic [7:0] SYNC_BYTE   = 8'h55;
  localparam logic [3:0] MAX_LEN     = 4'h8;
  localparam logic [3:0] DIAG_LEN    = 4'h8;

  // example schedule, loaded into every table at reset
  localparam int EX_N_ENT = 3;
  localparam logic [5:0] RST_ID  [EX_N_ENT] = '{6'h10, 6'h20, 6'h30};
  localparam logic [3:0] RST_LEN [EX_N_ENT] = '{4'h4, 4'h4, 4'h2};
  localparam logic       RST_TX  [EX_N_ENT] = '{1'b1, 1'b0, 1'b0};

  // example command frame layout
  localparam logic [5:0] EX_CMD_ID  = 6'h10;
  localparam logic [3:0] EX_CMD_LEN = 4'h4;
  localparam int EX_CNT_POS = 0;
  localparam int EX_CNT_W   = 8;
  localparam int EX_IGN_POS = 8;
  localparam int EX_SPD_POS = 9;
  localparam int EX_SPD_W   = 3;
  localparam int EX_TMP_POS = 16;
  localparam int EX_TMP_W   = 8;

  // temperature encoding: physical = raw * 0.8 - 35 degC for raw 0..253
  localparam logic [7:0] TMP_RAW_MAX   = 8'hfd;
  localparam logic [7:0] TMP_NOT_SUPP  = 8'hfe;
  localparam logic [7:0] TMP_NOT_AVAIL = 8'hff;
  localparam int TMP_SCALE_X10 = 8;
  localparam int TMP_OFFSET_C  = -35;

  typedef enum logic [1:0] {
    LMSF_TMP_OK    = 2'h0,
    LMSF_TMP_NSUPP = 2'h1,
    LMSF_TMP_NAVL  = 2'h2
  } lmsf_tmp_t;

  // link-side state codes shared by both ends
  typedef enum logic [6:0] {
    LMSF_WAIT = 7'h01,
    LMSF_BRK  = 7'h02,
    LMSF_SYNC = 7'h04,
    LMSF_PID  = 7'h08,
    LMSF_TXD  = 7'h10,
    LMSF_TXC  = 7'h20,
    LMSF_RXD  = 7'h40
  } lmsf_state_t;

  // protected identifier: parity in bits 7 and 6
  function automatic logic [7:0] lmsf_pid(input logic [5:0] id);
    return {id[1] ^ id[3] ^ id[4] ^ id[5], ~(id[0] ^ id[1] ^ id[2] ^ id[4]), id};
  endfunction : lmsf_pid

  // classic checksum: inverted sum with end-around carry over data bytes only
  function automatic logic [7:0] lmsf_csum(input logic [63:0] d, input logic [3:0] len);
    logic [8:0] s;
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = 9'h000;
      if (4'(i) < len) begin
        s   = {1'b0, acc} + {1'b0, d[8*i +: 8]};
        acc = s[7:0] + {7'h00, s[8]};
      end
    end
    return ~acc;
  endfunction : lmsf_csum

  // ids 0x3c..0x3f are not for application frames
  function automatic logic lmsf_is_special(input logic [5:0] id);
    return id[5:2] == 4'hf;
  endfunction : lmsf_is_special

  function automatic logic [3:0] lmsf_fix_len(input logic [3:0] l);
    return (l == 4'h0 || l > MAX_LEN) ? MAX_LEN : l;
  endfunction : lmsf_fix_len
endpackage : lmsf_pkg

// ===== verif/lin_master_schedule_framer_tb.sv
/* lin_master_schedule_framer_tb: both ends joined, default schedule then
   a diag table. assumes a 10-cycle ms tick to keep slots short */
`timescale 1ns/1ps
module lin_master_schedule_framer_tb;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        wr        = 1'b0;
  logic        sel       = 1'b0;
  logic        tsl       = 1'b1;
  logic        ttx       = 1'b0;
  logic        rdy       = 1'b1;
  logic [1:0]  idx       = 2'h0;
  logic [5:0]  id        = 6'h00;
  logic [5:0]  pid       = 6'h20;
  logic [3:0]  pln       = 4'h4;
  logic [7:0]  dly       = 8'h00;
  logic [63:0] txd       = 64'h00fe_0ba5;
  logic [63:0] dq        = 64'h0807_0605_0403_0201;
  logic [63:0] pd        = 64'h1234_5678;
  logic [63:0] rsd       = 64'hf0e0_d0c0_b0a0_9080;
  logic        rv, re, rm, rj, act, srv, sre, ign, ss, td, pe;
  logic [5:0]  rid, sid, cid;
  logic [63:0] rd, sd;
  logic [7:0]  cnt, tmp;
  logic [2:0]  spd;
  logic [1:0]  tc;
  int          mismatches = 0;
  int          samples_checked = 0;
  lmsf_if lin ();
  lmsf_master #(.N_ENT(3), .TICK_CYCLES(10)) lmsf_master_i (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .lin(lin), .sched_sel_i(sel), .tbl_wr_i(wr), .tbl_sel_i(tsl),
    .tbl_idx_i(idx), .tbl_id_i(id), .tbl_len_i(4'h8), .tbl_tx_i(ttx), .tbl_delay_i(dly),
    .tx_data_i(txd), .diag_req_data_i(dq), .slot_start_o(ss), .cur_id_o(cid), .act_tbl_o(act),
    .id_rej_o(rj), .rx_valid_o(rv), .rx_err_o(re), .rx_miss_o(rm), .rx_id_o(rid),
    .rx_data_o(rd));
  lmsf_slave lmsf_slave_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .lin(lin),
    .pub_id_i(pid), .pub_len_i(pln), .pub_data_i(pd), .diag_rsp_rdy_i(rdy),
    .diag_rsp_data_i(rsd), .sub_id_i(6'h01), .sub_len_i(4'h1), .rx_valid_o(srv),
    .rx_err_o(sre), .rx_id_o(sid), .rx_data_o(sd), .pid_err_o(pe), .tx_done_o(td),
    .cmd_cnt_o(cnt), .cmd_ign_o(ign), .cmd_spd_o(spd), .cmd_tmp_o(tmp), .tmp_code_o(tc));
  lmsf_chk_sva lmsf_chk_sva_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .brk(lin.brk),
    .m_vld(lin.m_vld), .m_byte(lin.m_byte), .s_vld(lin.s_vld));
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // bounded wait: 0 slave rx, 1 master rx, 2 rejected id
  task automatic wait_ev(input int k);
    for (int n = 0; n < 1000; n++) begin
      @(posedge clk_sys_i);
      #1;
      if ((k == 0 && srv === 1'b1) || (k == 1 && rv === 1'b1) || (k == 2 && rj === 1'b1))
        return;
    end
    chk(80'(k), 80'hffff, "event wait");
    close_out();
  endtask : wait_ev
  // table 1 entry; the diag ids ignore tx and length
  task automatic wr_ent(input logic [1:0] i, input logic [5:0] f, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr  <= 1'b1;
    idx <= i;
    id  <= f;
    dly <= d;
  endtask : wr_ent
  initial begin
    repeat (6) @(posedge clk_sys_i);
    chk({tmp, tc}, {8'hff, 2'h2}, "tmp reset");
    nrst_i <= 1'b1;
    wr_ent(2'h0, 6'h3c, 8'h02);
    wr_ent(2'h1, 6'h3d, 8'h03);
    wr_ent(2'h2, 6'h3e, 8'h01);
    @(posedge clk_sys_i);
    wr  <= 1'b0;
    sel <= 1'b1;
    // command frame decoded at the slave
    wait_ev(0);
    chk({sre, sid, sd[31:0]}, {1'b0, 6'h10, 32'h00fe_0ba5}, "cmd frame");
    chk({cnt, ign, spd}, {8'ha5, 1'b1, 3'h5}, "cmd fields");
    chk({tmp, tc}, {8'hfe, 2'h1}, "temperature");
    // slave publishes 0x20, nobody answers 0x30
    wait_ev(1);
    chk({rm, re, td, rid, rd[31:0]}, {2'h0, 1'b1, 6'h20, 32'h1234_5678}, "rsp 0x20");
    wait_ev(1);
    chk({rm, rid}, {1'b1, 6'h30}, "miss 0x30");
    // table 1 active after wrap: diag pair then reserved id
    wait_ev(0);
    chk({act, sid, sd}, {1'b1, 6'h3c, dq}, "diag req");
    wait_ev(1);
    chk({rm, re, rid, rd}, {2'h0, 6'h3d, rsd}, "diag rsp");
    wait_ev(2);
    chk({ss, lin.brk, cid, pe}, {1'b1, 1'b0, 6'h3e, 1'b0}, "rsv header");
    close_out();
  end
endmodule : lin_master_schedule_framer_tb

// ===== verif/lmsf_chk_sva.sv
/* lmsf_chk_sva: checks on the link wires between both ends.
   assumes master and slave share clk_sys_i */
`timescale 1ns/1ps
module lmsf_chk_sva (
  // clock, reset, link
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic       brk,
  input wire logic       m_vld,
  input wire logic [7:0] m_byte,
  input wire logic       s_vld
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // header shape, parity and legal ids
  a_sync_follows: assert property (brk |=> m_vld && m_byte == 8'h55)
    else $error("no sync");
  a_pid_parity: assert property (brk |-> ##2 m_vld && m_byte[7:6] ==
    {^{m_byte[1], m_byte[5:3]}, ~^{m_byte[4], m_byte[2:0]}}) else $error("bad parity");
  a_no_rsv_id: assert property (brk |-> ##2 m_byte[5:1] != 5'h1f)
    else $error("reserved id");
  // no second break within eight cycles of a break
  a_slot_gap: assert property (brk |=> !brk [*8]) else $error("short slot");
  a_one_talker: assert property (!(m_vld && s_vld)) else $error("clash");
  a_byte_framed: assert property ($rose(m_vld) |-> $past(brk))
    else $error("unframed");
  // diag frames carry eight bytes plus checksum
  a_req_eight: assert property (
    brk ##2 m_byte[5:0] == 6'h3c |=> m_vld [*8] ##1 m_vld ##1 !m_vld) else $error("req len");
  a_rsp_eight: assert property (
    brk ##2 m_byte[5:0] == 6'h3d ##1 s_vld |=> s_vld [*8] ##1 !s_vld) else $error("rsp len");
  c_req: cover property (brk ##2 m_byte[5:0] == 6'h3c);
  c_rsp: cover property (brk ##2 m_byte[5:0] == 6'h3d ##1 s_vld);
  c_pub: cover property ($rose(s_vld));
endmodule : lmsf_chk_sva
